// ---- peripheral_pin_router.sv ----
// What this block does
// - Only digital signals routed; analog stays fixed.
// - One input select per peripheral, common mapping.
// - One output select per pin, common mapping.
// - Direction bit governs driver for routed outputs.
// - Sync serial and I2C override direction.
// - Lock flag set blocks all select writes.
// - Lock flag changes only after 55, AA.
// - One-shot fuse: one clear, one set between resets; any reset rearms both.
// - Fuse clear: unlimited changes, sequence each time.
// - Select registers always read back.
// - Sleep never alters selections.
// - Power-on reset loads defaults, clears lock.
// - Other resets keep selections.
// - Codes 10111, 10110 pick port C pins.
//
// Implementation choices: register access over Avalon-MM and the register addresses.
module peripheral_pin_router (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic por_rst,
  input wire logic one_shot_lock_fuse,
  input wire pin_router_pkg::avs_req_t avs_req,
  output pin_router_pkg::avs_rsp_t avs_rsp,
  input wire logic [pin_router_pkg::NUM_PINS-1:0] pad_in,
  input wire logic [pin_router_pkg::NUM_PINS-1:0] pin_direction_control,
  input wire logic [pin_router_pkg::NUM_PINS-1:0] pin_latch,
  input wire logic [pin_router_pkg::NUM_SRC-1:0] periph_src,
  input wire logic [pin_router_pkg::NUM_SRC-1:0] periph_src_oe_n,
  output logic [pin_router_pkg::NUM_IN-1:0] periph_in,
  output pin_router_pkg::pad_drive_t pad_drive,
  output logic selection_lock_flag
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [4:0] in_sel_r [pin_router_pkg::NUM_IN];
  logic [4:0] out_sel_r [pin_router_pkg::NUM_PINS];
  logic lock_r;
  logic one_shot_r;
  logic clear_used_r;
  logic set_used_r;
  pin_router_pkg::unlock_state_t key_state_r;
  logic done_r;
  logic [31:0] readdata_r;
  logic [pin_router_pkg::NUM_PINS-1:0] pad_meta_r;
  logic [pin_router_pkg::NUM_PINS-1:0] pad_sync_r;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic req;
  logic acc_wr;
  logic aligned;
  logic [5:0] word;
  logic in_hit;
  logic out_hit;
  logic lock_hit;
  logic [2:0] in_idx;
  logic [4:0] out_idx;
  logic [7:0] wd8;
  logic wr_lock;
  logic sel_wr;
  logic dev_rst;
  logic flag_wr;
  logic new_flag;
  logic armed;

  assign req = avs_req.read | avs_req.write;
  assign aligned = (avs_req.address[1:0] == 2'h0);
  assign word = avs_req.address[7:2];
  assign in_hit = aligned && (word >= pin_router_pkg::IN_SEL_WORD)
                  && (word < pin_router_pkg::IN_SEL_WORD + 6'(pin_router_pkg::NUM_IN));
  assign out_hit = aligned && (word >= pin_router_pkg::OUT_SEL_WORD)
                   && (word < pin_router_pkg::OUT_SEL_WORD + 6'(pin_router_pkg::NUM_PINS));
  assign lock_hit = aligned && (word == pin_router_pkg::LOCK_CTRL_WORD);
  assign in_idx = 3'(word - pin_router_pkg::IN_SEL_WORD);
  assign out_idx = 5'(word - pin_router_pkg::OUT_SEL_WORD);
  assign wd8 = avs_req.writedata[7:0];
  // Write lands on the edge where waitrequest is seen low
  assign acc_wr = avs_req.write && done_r && avs_req.byteenable[0];
  assign wr_lock = acc_wr && lock_hit;
  assign sel_wr = acc_wr && (in_hit || out_hit);
  assign dev_rst = sys_rst || por_rst;
  assign armed = (key_state_r == pin_router_pkg::KEY_ARMED);
  assign new_flag = wd8[pin_router_pkg::LOCK_FLAG_BIT];

  // Whole response driven at once; waitrequest comes straight from the request
  assign avs_rsp = '{readdata: readdata_r, waitrequest: req && !done_r};
  assign selection_lock_flag = lock_r;

  // One wait cycle per access, then answer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= req && !done_r;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readdata_r <= 32'h0;
    end else if (avs_req.read && !done_r) begin
      if (in_hit) begin
        readdata_r <= {27'h0, in_sel_r[in_idx]};
      end else if (out_hit) begin
        readdata_r <= {27'h0, out_sel_r[out_idx]};
      end else if (lock_hit) begin
        readdata_r <= {30'h0, one_shot_r, lock_r};
      end else begin
        readdata_r <= 32'h0;
      end
    end
  end

  // ************************************************************
  // Unlock sequence
  // ************************************************************
  // key sequence
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      key_state_r <= pin_router_pkg::KEY_IDLE;
    end else if (wr_lock) begin
      case (key_state_r)
        pin_router_pkg::KEY_IDLE: begin
          key_state_r <= (wd8 == pin_router_pkg::KEY_FIRST) ? pin_router_pkg::KEY_GOT_FIRST
                                                              : pin_router_pkg::KEY_IDLE;
        end
        pin_router_pkg::KEY_GOT_FIRST: begin
          key_state_r <= (wd8 == pin_router_pkg::KEY_SECOND) ? pin_router_pkg::KEY_ARMED
                                                               : pin_router_pkg::KEY_IDLE;
        end
        default: begin
          key_state_r <= pin_router_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // Fuse is sampled while reset is held, then frozen
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      one_shot_r <= one_shot_lock_fuse;
    end
  end

  assign flag_wr = wr_lock && armed
                   && !(one_shot_r && (new_flag ? set_used_r : clear_used_r));

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      clear_used_r <= 1'b0;
      set_used_r <= 1'b0;
    end else if (flag_wr) begin
      if (new_flag) begin
        set_used_r <= 1'b1;
      end else begin
        clear_used_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (por_rst) begin
      lock_r <= 1'b0;
    end else if (flag_wr) begin
      lock_r <= new_flag;
    end
  end

  // ************************************************************
  // Selection registers
  // ************************************************************
  // no sleep term: selections hold through sleep
  always_ff @(posedge clock) begin
    if (por_rst) begin
      for (int i = 0; i < pin_router_pkg::NUM_IN; i++) begin
        in_sel_r[i] <= pin_router_pkg::IN_SEL_RESET[i*pin_router_pkg::SEL_W +: pin_router_pkg::SEL_W];
      end
    end else if (acc_wr && in_hit && !lock_r) begin
      in_sel_r[in_idx] <= wd8[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (por_rst) begin
      for (int i = 0; i < pin_router_pkg::NUM_PINS; i++) begin
        out_sel_r[i] <= pin_router_pkg::OUT_SEL_RESET;
      end
    end else if (acc_wr && out_hit && !lock_r) begin
      out_sel_r[out_idx] <= wd8[4:0];
    end
  end

  // ************************************************************
  // Crossbar
  // ************************************************************
  // Pads are asynchronous to this clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pad_meta_r <= '0;
      pad_sync_r <= '0;
    end else begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
    end
  end

  logic [pin_router_pkg::NUM_PINS-1:0] pad_out_v;
  logic [pin_router_pkg::NUM_PINS-1:0] pad_oe_n_v;

  // digital only; analog paths never enter here
  genvar g;
  generate
    for (g = 0; g < pin_router_pkg::NUM_IN; g++) begin : g_in
      input_select_mux u_in (
        .clock(clock),
        .sys_rst(sys_rst),
        .sel(in_sel_r[g]),
        .pins(pad_sync_r),
        .routed(periph_in[g])
      );
    end
    for (g = 0; g < pin_router_pkg::NUM_PINS; g++) begin : g_out
      pin_output_mux u_out (
        .clock(clock),
        .sys_rst(sys_rst),
        .sel(out_sel_r[g]),
        .sources(periph_src),
        .sources_oe_n(periph_src_oe_n),
        .latch(pin_latch[g]),
        .dir(pin_direction_control[g]),
        .pad_out(pad_out_v[g]),
        .pad_oe_n(pad_oe_n_v[g])
      );
    end
  endgenerate

  // Struct built in one place, so each field has a single driver
  assign pad_drive = '{out: pad_out_v, oe_n: pad_oe_n_v};

  // ************************************************************
  // Assertions
  // ************************************************************
  logic ovr_oe0;
  logic rd_ans;
  assign ovr_oe0 = periph_src_oe_n[out_sel_r[0]];
  assign rd_ans = avs_req.read && done_r;

  logic [pin_router_pkg::NUM_IN*pin_router_pkg::SEL_W-1:0] in_sel_flat;
  logic [pin_router_pkg::NUM_PINS*pin_router_pkg::SEL_W-1:0] out_sel_flat;

  // Tables packed flat, so freeze checks cover every register, not one
  always_comb begin
    for (int i = 0; i < pin_router_pkg::NUM_IN; i++) begin
      in_sel_flat[i*pin_router_pkg::SEL_W +: pin_router_pkg::SEL_W] = in_sel_r[i];
    end
    for (int i = 0; i < pin_router_pkg::NUM_PINS; i++) begin
      out_sel_flat[i*pin_router_pkg::SEL_W +: pin_router_pkg::SEL_W] = out_sel_r[i];
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst || por_rst);

  sequence s_first_key;
    key_state_r == pin_router_pkg::KEY_IDLE && wr_lock && wd8 == pin_router_pkg::KEY_FIRST;
  endsequence

  sequence s_bad_second;
    key_state_r == pin_router_pkg::KEY_GOT_FIRST && wr_lock && wd8 != pin_router_pkg::KEY_SECOND;
  endsequence

  sequence s_locked_sel_write;
    lock_r && sel_wr;
  endsequence

  a_key_advance: assert property (s_first_key |=> key_state_r == pin_router_pkg::KEY_GOT_FIRST)
    else $error("first key did not advance unlock");

  a_flag_needs_key: assert property ($changed(lock_r) && !$past(por_rst) |-> $past(armed))
    else $error("lock flag changed without key sequence");

  a_stray_abandon: assert property (s_bad_second |=> key_state_r == pin_router_pkg::KEY_IDLE)
    else $error("bad second key did not abandon sequence");

  a_locked_freeze: assert property (s_locked_sel_write |=> $stable(in_sel_flat) && $stable(out_sel_flat))
    else $error("select changed while locked");

  a_one_shot_spent: assert property (one_shot_r && set_used_r && clear_used_r |=> $stable(lock_r))
    else $error("one-shot lock changed twice");

  a_reusable_lock: assert property (!one_shot_r && wr_lock && armed |=> lock_r == $past(new_flag))
    else $error("armed flag write lost with fuse clear");

  a_readback_value: assert property (rd_ans && in_hit && in_idx == 3'h0
                                     |-> avs_rsp.readdata == {27'h0, in_sel_r[0]})
    else $error("input select readback mismatch");

  a_upper_zero: assert property (rd_ans |-> avs_rsp.readdata[31:5] == 27'h0)
    else $error("unimplemented read bits not zero");

  a_bus_answer: assert property (req && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
    else $error("no answer one cycle after request");

  a_dir_governs: assert property (!pin_router_pkg::OVERRIDE_MASK[out_sel_r[0]]
                                  |=> pad_drive.oe_n[0] == $past(pin_direction_control[0]))
    else $error("direction bit not driving enable");

  a_override_oe: assert property (pin_router_pkg::OVERRIDE_MASK[out_sel_r[0]]
                                  |=> pad_drive.oe_n[0] == $past(ovr_oe0))
    else $error("peripheral override of enable lost");

  a_port_c_pin7: assert property (in_sel_r[0] == pin_router_pkg::IN_CODE_PORT_C_PIN7
                                  |=> periph_in[0] == $past(pad_sync_r[23]))
    else $error("code 10111 not routed to port C pin 7");

  a_reserved_zero: assert property (in_sel_r[0][4:3] == pin_router_pkg::IN_RESERVED_TOP
                                    |=> !periph_in[0])
    else $error("reserved input code not quiet");

  a_fuse_frozen: assert property (!dev_rst |=> $stable(one_shot_r))
    else $error("fuse copy moved outside reset");

  // Power-on comes with the ordinary reset, so this one must not be disabled by it
  a_por_defaults: assert property (@(posedge clock) disable iff (1'b0)
                                   por_rst |=> !lock_r && in_sel_flat == pin_router_pkg::IN_SEL_RESET
                                   && out_sel_flat == {pin_router_pkg::NUM_PINS{pin_router_pkg::OUT_SEL_RESET}})
    else $error("power-on reset left select or lock");

  a_sysrst_keeps: assert property (@(posedge clock) disable iff (por_rst)
                                   sys_rst |=> $stable(out_sel_flat) && $stable(in_sel_flat))
    else $error("ordinary reset disturbed selections");

endmodule : peripheral_pin_router

// ---- pin_router_pkg.sv ----
package pin_router_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int SEL_W = 5;
  localparam int NUM_IN = 8;
  localparam int NUM_PINS = 24;
  localparam int NUM_SRC = 32;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [7:0] IN_SEL_BASE = 8'h00;
  localparam logic [7:0] OUT_SEL_BASE = 8'h40;
  localparam logic [7:0] LOCK_CTRL_ADDR = 8'hc0;
  localparam logic [5:0] IN_SEL_WORD = IN_SEL_BASE[7:2];
  localparam logic [5:0] OUT_SEL_WORD = OUT_SEL_BASE[7:2];
  localparam logic [5:0] LOCK_CTRL_WORD = LOCK_CTRL_ADDR[7:2];

  // Lock control register fields and keys
  localparam int LOCK_FLAG_BIT = 0;
  localparam int LOCK_FUSE_BIT = 1;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ************************************************************
  // Selection encodings and values after power-on reset
  // ************************************************************
  localparam logic [1:0] IN_RESERVED_TOP = 2'h3;
  localparam logic [4:0] IN_CODE_PORT_C_PIN7 = 5'h17;
  localparam logic [4:0] IN_CODE_PORT_C_PIN6 = 5'h16;
  localparam logic [4:0] SRC_PIN_LATCH = 5'h00;
  localparam logic [4:0] SRC_USART_SYNC_CLK = 5'h10;
  localparam logic [4:0] SRC_USART_SYNC_DATA = 5'h11;
  localparam logic [4:0] SRC_I2C_SCL = 5'h12;
  localparam logic [4:0] SRC_I2C_SDA = 5'h13;
  localparam logic [NUM_SRC-1:0] OVERRIDE_MASK = 32'h000f0000;
  localparam logic [4:0] OUT_SEL_RESET = 5'h00;
  // Peripheral i takes bits [i*5 +: 5]
  localparam logic [NUM_IN*SEL_W-1:0] IN_SEL_RESET = {5'h17, 5'h16, 5'h10, 5'h11, 5'h12, 5'h13, 5'h04, 5'h05};

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avs_rsp_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe_n;
  } pad_drive_t;

  typedef enum {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} unlock_state_t;

endpackage : pin_router_pkg

// ---- input_select_mux.sv ----
module input_select_mux (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] sel,
  input wire logic [pin_router_pkg::NUM_PINS-1:0] pins,
  output logic routed
);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      routed <= 1'b0;
    end else if (sel[4:3] == pin_router_pkg::IN_RESERVED_TOP) begin
      routed <= 1'b0;
    end else begin
      routed <= pins[sel];
    end
  end

endmodule : input_select_mux

// ---- pin_output_mux.sv ----
module pin_output_mux (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] sel,
  input wire logic [pin_router_pkg::NUM_SRC-1:0] sources,
  input wire logic [pin_router_pkg::NUM_SRC-1:0] sources_oe_n,
  input wire logic latch,
  input wire logic dir,
  output logic pad_out,
  output logic pad_oe_n
);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pad_out <= 1'b0;
    end else if (sel == pin_router_pkg::SRC_PIN_LATCH) begin
      pad_out <= latch;
    end else begin
      pad_out <= sources[sel];
    end
  end

  // Driver released during reset so no pad fights at power-up
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pad_oe_n <= 1'b1;
    end else if (pin_router_pkg::OVERRIDE_MASK[sel]) begin
      pad_oe_n <= sources_oe_n[sel];
    end else begin
      pad_oe_n <= dir;
    end
  end

endmodule : pin_output_mux

// ---- far_side_model.sv ----
module far_side_model #(
  parameter logic [31:0] SRC_PAT = 32'h9c3a65d2,
  parameter logic [31:0] OE_PAT = 32'h000a0000
) (
  input wire logic clock,
  input wire logic [pin_router_pkg::NUM_PINS-1:0] pad_level,
  input wire pin_router_pkg::pad_drive_t pad_drive,
  output logic [pin_router_pkg::NUM_PINS-1:0] pad_in,
  output logic [pin_router_pkg::NUM_SRC-1:0] periph_src,
  output logic [pin_router_pkg::NUM_SRC-1:0] periph_src_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Peripherals and pads
  // ************************************************************
  // Fixed patterns, so each output code gives a known level
  always_ff @(posedge clock) begin
    periph_src <= SRC_PAT;
    periph_src_oe_n <= OE_PAT;
  end

  // one shared pad
  // A driven pad reads back its own level, so both directions share it
  always_comb begin
    for (int p = 0; p < pin_router_pkg::NUM_PINS; p++) begin
      pad_in[p] = pad_drive.oe_n[p] ? pad_level[p] : pad_drive.out[p];
    end
  end
endmodule : far_side_model

// ---- peripheral_pin_router_test.sv ----
module peripheral_pin_router_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SRC_PAT = 32'h9c3a65d2;
  localparam logic [31:0] OE_PAT = 32'h000a0000;
  localparam logic [7:0] PIN2 = pin_router_pkg::OUT_SEL_BASE + 8'h08;
  localparam logic [7:0] LCK = pin_router_pkg::LOCK_CTRL_ADDR;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic por_rst = 1'b1;
  logic one_shot_lock_fuse = 1'b0;
  pin_router_pkg::avs_req_t avs_req = '0;
  pin_router_pkg::avs_rsp_t avs_rsp;
  logic [23:0] pad_level = 24'h0;
  logic [23:0] dir = 24'hffffff;
  logic [23:0] latch = 24'h000004;
  logic [23:0] pad_in;
  logic [31:0] src;
  logic [31:0] src_oe_n;
  logic [7:0] periph_in;
  pin_router_pkg::pad_drive_t pad_drive;
  logic selection_lock_flag;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic [4:0] codes[4];

  always #5 clock = ~clock;

  peripheral_pin_router peripheral_pin_router_i (.clock(clock), .sys_rst(sys_rst), .por_rst(por_rst),
    .one_shot_lock_fuse(one_shot_lock_fuse), .avs_req(avs_req), .avs_rsp(avs_rsp), .pad_in(pad_in),
    .pin_direction_control(dir), .pin_latch(latch), .periph_src(src), .periph_src_oe_n(src_oe_n),
    .periph_in(periph_in), .pad_drive(pad_drive), .selection_lock_flag(selection_lock_flag));
  far_side_model #(.SRC_PAT(SRC_PAT), .OE_PAT(OE_PAT)) far_side_model_i (.clock(clock),
    .pad_level(pad_level), .pad_drive(pad_drive), .pad_in(pad_in), .periph_src(src),
    .periph_src_oe_n(src_oe_n));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    avs_req.byteenable <= 4'hf;
    do begin
      @(posedge clock);
      n++;
    end while (avs_rsp.waitrequest !== 1'b0 && n < 100);
    if (n >= 100) errors++;
    q = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask : bus

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask : rdc

  task automatic key(input logic f);
    wr(LCK, {24'h0, pin_router_pkg::KEY_FIRST});
    wr(LCK, {24'h0, pin_router_pkg::KEY_SECOND});
    wr(LCK, {31'h0, f});
  endtask : key

  task automatic flag(input logic e);
    @(posedge clock);
    chk("lock_flag", {31'h0, e}, {31'h0, selection_lock_flag});
  endtask : flag

  task automatic rst(input logic por);
    @(posedge clock);
    sys_rst <= 1'b1;
    por_rst <= por;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
  endtask : rst

  task automatic done(input string t);
    $display("%s finished, errors %0d", t, errors);
  endtask : done

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdc("in_sel", pin_router_pkg::IN_SEL_BASE + 8'(4 * i), {27'h0, pin_router_pkg::IN_SEL_RESET[i*5+:5]});
    end
    rdc("out_sel", PIN2, 32'h0);
    rdc("lock_reg", LCK, 32'h0);
    rdc("unmapped", 8'hf0, 32'h0);
    done("defaults");

    wr(pin_router_pkg::IN_SEL_BASE, 32'hffffffff);
    rdc("in_sel_bits", pin_router_pkg::IN_SEL_BASE, 32'h1f);
    codes = '{5'h17, 5'h16, 5'h05, 5'h18};
    foreach (codes[k]) begin
      wr(pin_router_pkg::IN_SEL_BASE, {27'h0, codes[k]});
      pad_level <= (codes[k] < 5'h18) ? (24'h1 << codes[k]) : 24'hffffff;
      repeat (5) @(posedge clock);
      chk("periph_in0", {31'h0, codes[k] < 5'h18}, {31'h0, periph_in[0]});
      chk("periph_in1", {31'h0, pad_level[4]}, {31'h0, periph_in[1]});
    end
    done("input routing");

    codes = '{5'h00, 5'h03, 5'h12, 5'h13};
    foreach (codes[k]) begin
      wr(PIN2, {27'h0, codes[k]});
      wr(pin_router_pkg::OUT_SEL_BASE, {27'h0, codes[k]});
      // Direction opposite to the override level, so a lost override shows
      dir[2] <= ~k[0];
      repeat (3) @(posedge clock);
      chk("pad_out", {31'h0, codes[k] == 5'h0 ? latch[2] : SRC_PAT[codes[k]]}, {31'h0, pad_drive.out[2]});
      chk("pad_oe_n", {31'h0, codes[k] >= 5'h10 ? OE_PAT[codes[k]] : dir[2]}, {31'h0, pad_drive.oe_n[2]});
    end
    done("output routing");

    wr(LCK, 32'h1);
    flag(1'b0);
    key(1'b1);
    flag(1'b1);
    wr(PIN2, 32'h5);
    rdc("locked_sel", PIN2, 32'h13);
    wr(LCK, {24'h0, pin_router_pkg::KEY_FIRST});
    wr(LCK, 32'h0);
    wr(LCK, {24'h0, pin_router_pkg::KEY_SECOND});
    wr(LCK, 32'h0);
    flag(1'b1);
    key(1'b0);
    flag(1'b0);
    wr(PIN2, 32'h5);
    rdc("open_sel", PIN2, 32'h5);
    key(1'b1);
    key(1'b0);
    flag(1'b0);
    done("lock");

    one_shot_lock_fuse <= 1'b1;
    key(1'b1);
    rst(1'b1);
    flag(1'b0);
    rdc("por_in_sel", pin_router_pkg::IN_SEL_BASE, {27'h0, pin_router_pkg::IN_SEL_RESET[4:0]});
    rdc("por_out_sel", PIN2, 32'h0);
    wr(PIN2, 32'h7);
    key(1'b1);
    rst(1'b0);
    flag(1'b1);
    rdc("kept_sel", PIN2, 32'h7);
    key(1'b0);
    flag(1'b0);
    key(1'b1);
    flag(1'b1);
    key(1'b0);
    flag(1'b1);
    rdc("lock_reg", LCK, 32'h3);
    done("one shot");
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    tally_and_finish();
  end
endmodule : peripheral_pin_router_test
